/* File: design/dcks_decoder.sv */
// ddr2 command and clock-enable state decoder, top level
`include "dcks_regs.svh"
module dcks_decoder #(
  parameter int LANES = 2,
  parameter int LANEW = 8,
  parameter int ROWW  = 13
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // command pins
  input  wire logic                    cke,
  input  wire dcks_pkg::dcks_pins_t    pins,
  input  wire logic [1:0]              ba,
  input  wire logic [ROWW-1:0]         addr,
  input  wire logic                    odt,
  // write data pins
  input  wire logic [LANES*LANEW-1:0]  wrData,
  input  wire logic [LANES-1:0]        wrMask,
  // decoded state
  output dcks_pkg::dcks_cmd_t          cmd_r,
  output dcks_pkg::dcks_state_t        state_r,
  output logic [3:0]                   bankOpen_r,
  output dcks_pkg::dcks_burst_t        burst_r,
  output logic [3:0][ROWW-1:0]         modeReg_r,
  output logic                         odtOn_r,
  // lane writes
  output logic [LANES*LANEW-1:0]       laneData_r,
  output logic [LANES-1:0]             laneStrobe_r
);

  localparam logic [1:0] BURST_LAST = 2'(`DCKS_BURST_CYCLES - 1);

  logic                  ckePrev_r;
  dcks_pkg::dcks_cmd_t   cmdNow;
  dcks_pkg::dcks_state_t stateNxt;
  logic                  inNormal;
  logic                  srWake;
  logic                  burstStart;
  logic                  burstEnd;
  logic                  startWrite;

  // ***********************
  // command decode
  // ***********************
  assign cmdNow = dcks_pkg::dcks_decode(ckePrev_r, cke, pins,
                                        addr[`DCKS_AP_BIT]);
  assign inNormal = state_r == dcks_pkg::ST_NORMAL;
  // exit seen from the enable pin alone, commands don't care
  assign srWake = (state_r == dcks_pkg::ST_SREF) && cke;

  always_ff @(posedge clk)
  begin
    if (srst)
      ckePrev_r <= 1'b0;
    else
      ckePrev_r <= cke;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cmd_r <= dcks_pkg::CMD_NOP;
    else
      cmd_r <= cmdNow;
  end

  // ***********************
  // power state
  // ***********************
  always_comb
  begin
    stateNxt = state_r;
    unique case (state_r)
      dcks_pkg::ST_NORMAL:
      begin
        if (cmdNow == dcks_pkg::CMD_PD_IN)
          stateNxt = (|bankOpen_r) ? dcks_pkg::ST_PD_ACT
                                   : dcks_pkg::ST_PD_PRE;
        else if (cmdNow == dcks_pkg::CMD_SREF_IN && bankOpen_r == 4'h0)
          stateNxt = dcks_pkg::ST_SREF;
      end
      dcks_pkg::ST_PD_PRE,
      dcks_pkg::ST_PD_ACT:
      begin
        if (cmdNow == dcks_pkg::CMD_CKE_UP)
          stateNxt = dcks_pkg::ST_NORMAL;
      end
      dcks_pkg::ST_SREF:
      begin
        if (srWake)
          stateNxt = dcks_pkg::ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_r <= dcks_pkg::ST_NORMAL;
    else
      state_r <= stateNxt;
  end

  // termination follows its pin except in self refresh
  always_ff @(posedge clk)
  begin
    if (srst)
      odtOn_r <= 1'b0;
    else
      odtOn_r <= odt && stateNxt != dcks_pkg::ST_SREF;
  end

  // ***********************
  // mode registers
  // ***********************
  always_ff @(posedge clk)
  begin
    if (srst)
      modeReg_r <= {4{`DCKS_MR_RST}};
    else if (inNormal && cmdNow == dcks_pkg::CMD_MRS)
      modeReg_r[ba] <= addr;
  end

  // ***********************
  // bursts
  // ***********************
  assign startWrite = cmdNow == dcks_pkg::CMD_WR ||
                      cmdNow == dcks_pkg::CMD_WRA;
  assign burstStart = inNormal && !burst_r.active &&
                      (startWrite || cmdNow == dcks_pkg::CMD_RD ||
                       cmdNow == dcks_pkg::CMD_RDA);
  assign burstEnd = burst_r.active && burst_r.count == BURST_LAST;

  always_ff @(posedge clk)
  begin
    if (srst)
      burst_r <= '0;
    else if (burstStart)
    begin
      burst_r.active  <= 1'b1;
      burst_r.write   <= startWrite;
      burst_r.autoPre <= addr[`DCKS_AP_BIT];
      burst_r.bank    <= ba;
      burst_r.count   <= 2'h0;
    end
    else if (burstEnd)
      burst_r.active <= 1'b0;
    else if (burst_r.active)
      // later commands never cut the burst short
      burst_r.count <= burst_r.count + 2'h1;
  end

  // ***********************
  // bank tracking
  // ***********************
  always_ff @(posedge clk)
  begin
    if (srst)
      bankOpen_r <= `DCKS_BANKS_RST;
    else
    begin
      if (burstEnd && burst_r.autoPre)
        bankOpen_r[burst_r.bank] <= 1'b0;
      if (inNormal)
      begin
        unique case (cmdNow)
          dcks_pkg::CMD_ACT:  bankOpen_r[ba] <= 1'b1;
          dcks_pkg::CMD_PRE:  bankOpen_r[ba] <= 1'b0;
          dcks_pkg::CMD_PREA: bankOpen_r <= 4'h0;
          default: ;
        endcase
      end
    end
  end

  // ***********************
  // write masking
  // ***********************
  dcks_wmask #(
    .LANES (LANES),
    .LANEW (LANEW)
  ) u_wmask (
    .clk          (clk),
    .srst         (srst),
    .wrWindow     (burst_r.active && burst_r.write),
    .wrData       (wrData),
    .wrMask       (wrMask),
    .laneData_r   (laneData_r),
    .laneStrobe_r (laneStrobe_r)
  );

  // ***********************
  // checks
  // ***********************
  property p_nop_idle;
    @(posedge clk) disable iff (srst)
    (cmdNow == dcks_pkg::CMD_NOP && !burstEnd) |=>
      $stable(bankOpen_r) && cmd_r == dcks_pkg::CMD_NOP;
  endproperty
  a_nop_idle: assert property (p_nop_idle)
    else $error("nop changed bank state");

  property p_desel;
    @(posedge clk) disable iff (srst)
    (pins.csN && ckePrev_r && cke) |=> cmd_r == dcks_pkg::CMD_DESEL;
  endproperty
  a_desel: assert property (p_desel)
    else $error("deselect not decoded");

  sequence s_burst_go;
    burstStart;
  endsequence
  sequence s_burst_run;
    burst_r.active [*2] ##1 !burst_r.active;
  endsequence
  property p_burst_full;
    @(posedge clk) disable iff (srst)
    s_burst_go |=> s_burst_run;
  endproperty
  a_burst_full: assert property (p_burst_full)
    else $error("burst cut short");

  property p_nop_keeps_burst;
    @(posedge clk) disable iff (srst)
    (burst_r.active && !burstEnd && cmdNow == dcks_pkg::CMD_NOP) |=>
      burst_r.active;
  endproperty
  a_nop_keeps_burst: assert property (p_nop_keeps_burst)
    else $error("nop stopped burst");

  property p_mrs;
    @(posedge clk) disable iff (srst)
    (inNormal && cmdNow == dcks_pkg::CMD_MRS) |=>
      modeReg_r[$past(ba)] == $past(addr);
  endproperty
  a_mrs: assert property (p_mrs)
    else $error("mode register not written");

  property p_act;
    @(posedge clk) disable iff (srst)
    (inNormal && cmdNow == dcks_pkg::CMD_ACT) |=> bankOpen_r[$past(ba)];
  endproperty
  a_act: assert property (p_act)
    else $error("activate did not open bank");

  property p_rd_start;
    @(posedge clk) disable iff (srst)
    (burstStart && cmdNow == dcks_pkg::CMD_RDA) |=>
      !burst_r.write && burst_r.autoPre && burst_r.bank == $past(ba);
  endproperty
  a_rd_start: assert property (p_rd_start)
    else $error("read burst set up wrong");

  property p_sref_odt;
    @(posedge clk) disable iff (srst)
    state_r == dcks_pkg::ST_SREF |-> !odtOn_r;
  endproperty
  a_sref_odt: assert property (p_sref_odt)
    else $error("termination on in self refresh");

  property p_sr_wake;
    @(posedge clk) disable iff (srst)
    srWake |=> state_r == dcks_pkg::ST_NORMAL;
  endproperty
  a_sr_wake: assert property (p_sr_wake)
    else $error("self refresh exit missed");

  property p_pd_entry;
    @(posedge clk) disable iff (srst)
    (inNormal && cmdNow == dcks_pkg::CMD_PD_IN) |=>
      state_r == ($past(|bankOpen_r) ? dcks_pkg::ST_PD_ACT
                                     : dcks_pkg::ST_PD_PRE);
  endproperty
  a_pd_entry: assert property (p_pd_entry)
    else $error("wrong power-down state");

  property p_decode_reg;
    @(posedge clk) disable iff (srst)
    1'b1 |=> cmd_r == dcks_pkg::dcks_decode($past(ckePrev_r),
      $past(cke), $past(pins), $past(addr[`DCKS_AP_BIT]));
  endproperty
  a_decode_reg: assert property (p_decode_reg)
    else $error("command register disagrees with pins");

  property p_sref_entry;
    @(posedge clk) disable iff (srst)
    (inNormal && cmdNow == dcks_pkg::CMD_SREF_IN && bankOpen_r == 4'h0)
      |=> state_r == dcks_pkg::ST_SREF;
  endproperty
  a_sref_entry: assert property (p_sref_entry)
    else $error("self refresh not entered");

  property p_pd_exit;
    @(posedge clk) disable iff (srst)
    ((state_r == dcks_pkg::ST_PD_PRE || state_r == dcks_pkg::ST_PD_ACT) &&
     cmdNow == dcks_pkg::CMD_CKE_UP) |=> state_r == dcks_pkg::ST_NORMAL;
  endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("power-down exit missed");

  property p_illegal_hold;
    @(posedge clk) disable iff (srst)
    (cmdNow == dcks_pkg::CMD_ILLEGAL && !burstEnd && !srWake) |=>
      $stable(state_r) && $stable(bankOpen_r) && $stable(modeReg_r);
  endproperty
  a_illegal_hold: assert property (p_illegal_hold)
    else $error("illegal command changed state");

  property p_wr_start;
    @(posedge clk) disable iff (srst)
    (burstStart && startWrite) |=>
      burst_r.write && burst_r.bank == $past(ba) && burst_r.count == 2'h0;
  endproperty
  a_wr_start: assert property (p_wr_start)
    else $error("write burst set up wrong");

endmodule : dcks_decoder

/* File: design/dcks_regs.svh */
// constants of the ddr2 command and clock-enable state decoder
`ifndef DCKS_REGS_SVH
`define DCKS_REGS_SVH
`define DCKS_BURST_CYCLES 2
`define DCKS_AP_BIT       10
`define DCKS_MR_RST       13'h0000
`define DCKS_BANKS_RST    4'h0
`endif

/* File: design/dcks_pkg.sv */
// types and decode function of the ddr2 command decoder
package dcks_pkg;

  typedef enum logic [3:0] {
    CMD_NOP     = 4'h0,
    CMD_DESEL   = 4'h1,
    CMD_MRS     = 4'h2,
    CMD_REF     = 4'h3,
    CMD_PRE     = 4'h4,
    CMD_PREA    = 4'h5,
    CMD_ACT     = 4'h6,
    CMD_WR      = 4'h7,
    CMD_WRA     = 4'h8,
    CMD_RD      = 4'h9,
    CMD_RDA     = 4'hA,
    CMD_PD_IN   = 4'hB,
    CMD_SREF_IN = 4'hC,
    CMD_CKE_UP  = 4'hD,
    CMD_HOLD    = 4'hE,
    CMD_ILLEGAL = 4'hF
  } dcks_cmd_t;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_PD_PRE = 2'b01,
    ST_PD_ACT = 2'b10,
    ST_SREF   = 2'b11
  } dcks_state_t;

  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } dcks_pins_t;

  typedef struct packed {
    logic       active;
    logic       write;
    logic       autoPre;
    logic [1:0] bank;
    logic [1:0] count;
  } dcks_burst_t;

  function automatic dcks_cmd_t dcks_decode(
    input logic       ckePrev,
    input logic       ckeNow,
    input dcks_pins_t p,
    input logic       a10
  );
    logic nopLike;
    logic refLike;
    nopLike = p.csN | (p.rasN & p.casN & p.weN);
    refLike = ~p.csN & ~p.rasN & ~p.casN & p.weN;
    if (!ckePrev && ckeNow)
      return nopLike ? CMD_CKE_UP : CMD_ILLEGAL;
    if (ckePrev && !ckeNow)
    begin
      if (nopLike)
        return CMD_PD_IN;
      return refLike ? CMD_SREF_IN : CMD_ILLEGAL;
    end
    if (!ckePrev)
      return CMD_HOLD;
    if (p.csN)
      return CMD_DESEL;
    unique case ({p.rasN, p.casN, p.weN})
      3'b000: return CMD_MRS;
      3'b001: return CMD_REF;
      3'b010: return a10 ? CMD_PREA : CMD_PRE;
      3'b011: return CMD_ACT;
      3'b100: return a10 ? CMD_WRA : CMD_WR;
      3'b101: return a10 ? CMD_RDA : CMD_RD;
      3'b111: return CMD_NOP;
      default: return CMD_ILLEGAL;
    endcase
  endfunction : dcks_decode

endpackage : dcks_pkg

/* File: design/dcks_wmask.sv */
// per-lane write data masking stage
module dcks_wmask #(
  parameter int LANES = 2,
  parameter int LANEW = 8
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // write data in
  input  wire logic                   wrWindow,
  input  wire logic [LANES*LANEW-1:0] wrData,
  input  wire logic [LANES-1:0]       wrMask,
  // lane writes out
  output logic      [LANES*LANEW-1:0] laneData_r,
  output logic      [LANES-1:0]       laneStrobe_r
);

  // ***********************
  // lane strobes
  // ***********************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      laneStrobe_r <= '0;
      laneData_r   <= '0;
    end
    else
    begin
      laneStrobe_r <= {LANES{wrWindow}} & ~wrMask;
      laneData_r   <= wrData;
    end
  end

  property p_mask_inhibit;
    @(posedge clk) disable iff (srst)
    wrWindow |=> laneStrobe_r == ~$past(wrMask);
  endproperty
  a_mask_inhibit: assert property (p_mask_inhibit)
    else $error("masked lane written");

  property p_no_window;
    @(posedge clk) disable iff (srst)
    !wrWindow |=> laneStrobe_r == '0;
  endproperty
  a_no_window: assert property (p_no_window)
    else $error("lane written outside write burst");

endmodule : dcks_wmask

/* File: bench/dcks_ctl.sv */
// controller model driving command, address and write data pins
module dcks_ctl (
  // clock
  input  wire logic            clk,
  // command and data pins
  output logic                 cke,
  output dcks_pkg::dcks_pins_t pins,
  output logic [1:0]           ba,
  output logic [12:0]          addr,
  output logic                 odt,
  output logic [15:0]          wrData,
  output logic [1:0]           wrMask
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // pin drive
  // ********
  initial
  begin
    cke = 1'b1;
    pins = 4'hF;
    ba = 2'h0;
    addr = 13'h0000;
    odt = 1'b0;
    wrData = 16'h0000;
    wrMask = 2'h0;
  end
  // deselect, released bank, address and data lines show the inverse, mask cleared
  task automatic rel();
    pins = 4'hF;
    ba = ~ba;
    addr = ~addr;
    wrData = ~wrData;
    wrMask = 2'h0;
  endtask : rel
  task automatic cmd(input logic c, input logic [3:0] p,
                     input logic [1:0] b, input logic [12:0] a);
    cke = c;
    pins = p;
    ba = b;
    addr = a;
    @(posedge clk);
    #1;
  endtask : cmd
  // enable edge with nop, deselect or refresh pins, level held three clocks
  task automatic ckeMove(input logic c, input logic [3:0] p);
    cmd(c, p, 2'h0, 13'h0000);
    repeat (2)
    begin
      rel();
      @(posedge clk);
      #1;
    end
  endtask : ckeMove
  task automatic beat(input logic [1:0] m, input logic [15:0] d);
    pins = 4'hF;
    wrMask = m;
    wrData = d;
    @(posedge clk);
    #1;
  endtask : beat
endmodule : dcks_ctl

/* File: bench/tb_top.sv */
// self-checking testbench of the ddr2 command decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk;
  logic                    srst;
  logic                    cke;
  dcks_pkg::dcks_pins_t    pins;
  logic [1:0]              ba;
  logic [12:0]             addr;
  logic                    odt;
  logic [15:0]             wrData;
  logic [1:0]              wrMask;
  dcks_pkg::dcks_cmd_t     cmd_r;
  dcks_pkg::dcks_state_t   state_r;
  logic [3:0]              bankOpen_r;
  dcks_pkg::dcks_burst_t   burst_r;
  logic [3:0][12:0]        modeReg_r;
  logic                    odtOn_r;
  logic [15:0]             laneData_r;
  logic [1:0]              laneStrobe_r;
  int                      mismatches = 0;
  int                      checks_done = 0;
  // decode rows: pins and address ten beside the decoded command
  localparam logic [4:0] rowIn [13] = '{5'h00, 5'h02, 5'h04, 5'h05,
    5'h06, 5'h0A, 5'h0B, 5'h08, 5'h09, 5'h0E, 5'h10, 5'h1D, 5'h0C};
  localparam dcks_pkg::dcks_cmd_t rowCmd [13] = '{dcks_pkg::CMD_MRS,
    dcks_pkg::CMD_REF, dcks_pkg::CMD_PRE, dcks_pkg::CMD_PREA,
    dcks_pkg::CMD_ACT, dcks_pkg::CMD_RD, dcks_pkg::CMD_RDA,
    dcks_pkg::CMD_WR, dcks_pkg::CMD_WRA, dcks_pkg::CMD_NOP,
    dcks_pkg::CMD_DESEL, dcks_pkg::CMD_DESEL, dcks_pkg::CMD_ILLEGAL};
  dcks_decoder dcks_decoder_inst (.clk(clk), .srst(srst), .cke(cke),
    .pins(pins), .ba(ba), .addr(addr), .odt(odt), .wrData(wrData),
    .wrMask(wrMask), .cmd_r(cmd_r), .state_r(state_r),
    .bankOpen_r(bankOpen_r), .burst_r(burst_r), .modeReg_r(modeReg_r),
    .odtOn_r(odtOn_r), .laneData_r(laneData_r),
    .laneStrobe_r(laneStrobe_r));
  dcks_ctl dcks_ctl_inst (.clk(clk), .cke(cke), .pins(pins), .ba(ba),
    .addr(addr), .odt(odt), .wrData(wrData), .wrMask(wrMask));
  // ********
  // helpers
  // ********
  task automatic check(input string n, input logic [15:0] g,
                       input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #5000;
    mismatches++;
    stop_test();
  end
  // ********
  // tests
  // ********
  initial
  begin
    srst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    check("cmd", 16'(cmd_r), 16'(dcks_pkg::CMD_NOP));
    check("state", 16'(state_r), 16'(dcks_pkg::ST_NORMAL));
    check("burst", 16'(burst_r), 16'h0000);
    check("mode", 16'(modeReg_r[3]), 16'h0000);
    srst = 1'b0;
    @(posedge clk);
    #1;
    $display("test reset done");
    for (int i = 0; i < 13; i++)
    begin
      dcks_ctl_inst.cmd(1'b1, rowIn[i][4:1], 2'h0,
                        {2'h0, rowIn[i][0], 10'h000});
      check("cmd", 16'(cmd_r), 16'(rowCmd[i]));
    end
    dcks_ctl_inst.cmd(1'b1, 4'h2, 2'h0, 13'h0400);
    dcks_ctl_inst.cmd(1'b1, 4'hF, 2'h0, 13'h0000);
    check("banks", 16'(bankOpen_r), 16'h0000);
    $display("test decode table done");
    dcks_ctl_inst.cmd(1'b1, 4'h0, 2'h2, 13'h0ABC);
    check("mode", 16'(modeReg_r[2]), 16'h0ABC);
    dcks_ctl_inst.cmd(1'b1, 4'h3, 2'h1, 13'h0000);
    check("banks", 16'(bankOpen_r), 16'h0002);
    dcks_ctl_inst.cmd(1'b1, 4'h5, 2'h1, 13'h0400);
    check("burst", 16'(burst_r), 16'h0054);
    dcks_ctl_inst.cmd(1'b1, 4'h4, 2'h0, 13'h0000);
    check("burst", 16'(burst_r), 16'h0055);
    dcks_ctl_inst.cmd(1'b1, 4'h7, 2'h0, 13'h0000);
    check("active", 16'(burst_r.active), 16'h0000);
    check("banks", 16'(bankOpen_r), 16'h0000);
    $display("test burst done");
    dcks_ctl_inst.cmd(1'b1, 4'h3, 2'h3, 13'h0000);
    dcks_ctl_inst.ckeMove(1'b0, 4'h7);
    check("state", 16'(state_r), 16'(dcks_pkg::ST_PD_ACT));
    dcks_ctl_inst.ckeMove(1'b1, 4'hF);
    check("state", 16'(state_r), 16'(dcks_pkg::ST_NORMAL));
    dcks_ctl_inst.cmd(1'b1, 4'h2, 2'h0, 13'h0400);
    dcks_ctl_inst.ckeMove(1'b0, 4'hF);
    check("state", 16'(state_r), 16'(dcks_pkg::ST_PD_PRE));
    dcks_ctl_inst.ckeMove(1'b1, 4'h7);
    dcks_ctl_inst.odt = 1'b1;
    dcks_ctl_inst.ckeMove(1'b0, 4'h1);
    check("state", 16'(state_r), 16'(dcks_pkg::ST_SREF));
    check("odt", 16'(odtOn_r), 16'h0000);
    dcks_ctl_inst.ckeMove(1'b1, 4'hF);
    check("state", 16'(state_r), 16'(dcks_pkg::ST_NORMAL));
    check("odt", 16'(odtOn_r), 16'h0001);
    $display("test power states done");
    dcks_ctl_inst.cmd(1'b1, 4'h3, 2'h0, 13'h0000);
    dcks_ctl_inst.cmd(1'b1, 4'h4, 2'h0, 13'h0000);
    dcks_ctl_inst.beat(2'h1, 16'hA55A);
    check("strobe", 16'(laneStrobe_r), 16'h0002);
    check("data", laneData_r, 16'hA55A);
    dcks_ctl_inst.beat(2'h2, 16'h3CC3);
    check("strobe", 16'(laneStrobe_r), 16'h0001);
    check("data", laneData_r, 16'h3CC3);
    dcks_ctl_inst.beat(2'h0, 16'h0000);
    check("strobe", 16'(laneStrobe_r), 16'h0000);
    $display("test write mask done");
    srst = 1'b1;
    @(posedge clk);
    #1;
    check("banks", 16'(bankOpen_r), 16'h0000);
    check("mode", 16'(modeReg_r[2]), 16'h0000);
    srst = 1'b0;
    @(posedge clk);
    #1;
    check("cmd", 16'(cmd_r), 16'(dcks_pkg::CMD_CKE_UP));
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : tb_top
